// *** verilog/bss_defines.vh ***
`ifndef BSS_DEFINES_VH
`define BSS_DEFINES_VH

// ----------------------------------------------------------------------
// Code modes
// ----------------------------------------------------------------------
`define BSS_MODE_8BIT       2'd0
`define BSS_MODE_5BIT       2'd1
`define BSS_MODE_6BIT       2'd2

// ----------------------------------------------------------------------
// Voltage codes and reference steps (6.25 mV per LSB)
// ----------------------------------------------------------------------
`define BSS_STEP_UV         6250
`define BSS_BOOT_MV         1100
`define BSS_BOOT_STEPS      12'd176
`define BSS_NO_LOAD_CODE    5'h1f

// ----------------------------------------------------------------------
// Timing, 100 MHz clock
// ----------------------------------------------------------------------
`define BSS_CLK_NS          10
`define BSS_INIT_WAIT_NS    1100000
`define BSS_INIT_WAIT_CYC   (`BSS_INIT_WAIT_NS / `BSS_CLK_NS)
`define BSS_BOOT_HOLD_NS    93000
`define BSS_BOOT_HOLD_CYC   (`BSS_BOOT_HOLD_NS / `BSS_CLK_NS)
`define BSS_PG_DELAY_NS     93000
`define BSS_PG_DELAY_CYC    (`BSS_PG_DELAY_NS / `BSS_CLK_NS)
`define BSS_BLANK_NS        20
`define BSS_BLANK_CYC       ((`BSS_BLANK_NS + `BSS_CLK_NS - 1) / `BSS_CLK_NS)
`define BSS_ZERO_I_NS       35
`define BSS_ZERO_I_CYC      (`BSS_ZERO_I_NS / `BSS_CLK_NS)

`endif

// *** verilog/bss_delay_timer.v ***
`timescale 1ns/1ns
// Loadable down counter; done is high while the count is zero and no load is requested
module bss_delay_timer #(
    parameter WIDTH = 20
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // Control
    input  wire             load_i,
    input  wire [WIDTH-1:0] count_i,
    // Status
    output wire             done_o
);

    reg [WIDTH-1:0] cnt_reg;

    // Count down to zero, reload on request
    always @(posedge clk_i)
    begin
        if (rst_i)
            cnt_reg <= {WIDTH{1'b0}};
        else if (load_i)
            cnt_reg <= count_i;
        else if (cnt_reg != {WIDTH{1'b0}})
            cnt_reg <= cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end

    assign done_o = (cnt_reg == {WIDTH{1'b0}}) && !load_i;

endmodule // bss_delay_timer

// *** verilog/bss_deadtime.v ***
`timescale 1ns/1ns
`include "bss_defines.vh"
// Adaptive deadtime for one high-side / low-side gate pair
module bss_deadtime #(
    parameter BLANK_CYC  = `BSS_BLANK_CYC,
    parameter ZERO_I_CYC = `BSS_ZERO_I_CYC
) (
    // Clock and reset
    input  wire clk_i,
    input  wire rst_i,
    // Control
    input  wire drive_en_i,
    input  wire pwm_i,
    // Comparators
    input  wire sw_node_low_i,
    input  wire sw_node_rev_i,
    input  wire low_gate_below_i,
    input  wire high_gate_off_i,
    input  wire sw_node_below_i,
    // Gate commands
    output reg  high_side_gate_o,
    output reg  low_side_gate_o
);

    localparam ST_OFF   = 2'd0;
    localparam ST_LOW   = 2'd1;
    localparam ST_TO_HI = 2'd2;
    localparam ST_HIGH  = 2'd3;

    reg [1:0] state_reg;
    reg [3:0] blank_reg;
    reg [3:0] zero_reg;

    // Gate sequencing state machine
    always @(posedge clk_i)
    begin
        if (rst_i || !drive_en_i)
        begin
            state_reg        <= ST_OFF;
            high_side_gate_o <= 1'b0;
            low_side_gate_o  <= 1'b0;
            blank_reg        <= 4'h0;
            zero_reg         <= 4'h0;
        end
        else
        begin
            case (state_reg)
                ST_OFF:
                begin
                    state_reg       <= pwm_i ? ST_TO_HI : ST_LOW;
                    blank_reg       <= BLANK_CYC[3:0];
                    zero_reg        <= 4'h0;
                    low_side_gate_o <= 1'b0;
                end
                ST_LOW:
                begin
                    low_side_gate_o <= 1'b1;
                    if (pwm_i)
                    begin
                        low_side_gate_o <= 1'b0;
                        blank_reg       <= BLANK_CYC[3:0];
                        zero_reg        <= 4'h0;
                        state_reg       <= ST_TO_HI;
                    end
                end
                ST_TO_HI:
                begin
                    if (blank_reg != 4'h0)
                        blank_reg <= blank_reg - 4'h1;
                    if (low_gate_below_i && zero_reg < ZERO_I_CYC[3:0])
                        zero_reg <= zero_reg + 4'h1;
                    if (!pwm_i)
                        state_reg <= ST_LOW;
                    else if ((blank_reg == 4'h0 && (sw_node_low_i || sw_node_rev_i))
                             || (zero_reg == ZERO_I_CYC[3:0]))
                    begin
                        high_side_gate_o <= 1'b1;
                        state_reg        <= ST_HIGH;
                    end
                end
                ST_HIGH:
                begin
                    if (!pwm_i)
                        high_side_gate_o <= 1'b0;
                    if (!pwm_i && (high_gate_off_i || sw_node_below_i))
                    begin
                        low_side_gate_o <= 1'b1;
                        state_reg       <= ST_LOW;
                    end
                end
                default:
                    state_reg <= ST_OFF;
            endcase
        end
    end

endmodule // bss_deadtime

// *** verilog/bss_softstart_seq.v ***
`timescale 1ns/1ns
`include "bss_defines.vh"

module bss_softstart_seq #(
    parameter CODE_W     = 8,
    parameter REF_W      = 12,
    parameter WAIT_W     = 20,
    parameter INIT_WAIT  = `BSS_INIT_WAIT_CYC,
    parameter BOOT_HOLD  = `BSS_BOOT_HOLD_CYC,
    parameter PG_DELAY   = `BSS_PG_DELAY_CYC
) (
    // Clock and reset
    input  wire              clk_i,
    input  wire              rst_i,
    // Supply and enable comparators
    input  wire              logic_supply_ok_i,
    input  wire              enable_above_i,
    input  wire              driver_bias_supply_ok_i,
    // Mode and voltage code
    input  wire [1:0]        code_mode_i,
    input  wire [CODE_W-1:0] voltage_code_i,
    input  wire              code_valid_i,
    input  wire [REF_W-1:0]  code_steps_i,
    // Soft-start oscillator and analog comparators
    input  wire              ss_tick_i,
    input  wire              feedback_sense_above_i,
    input  wire              output_sense_in_window_i,
    // Modulation and deadtime comparators
    input  wire              pwm_i,
    input  wire              sw_node_low_i,
    input  wire              sw_node_rev_i,
    input  wire              low_gate_below_i,
    input  wire              high_gate_off_i,
    input  wire              sw_node_below_i,
    // Gate and status outputs
    output wire              high_side_gate_o,
    output wire              low_side_gate_o,
    output reg               power_good_out_o,
    output reg  [REF_W-1:0]  ref_steps_o,
    output reg  [2:0]        seq_state_o,
    output reg  [CODE_W-1:0] latched_code_o
);

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam ST_SHUTDOWN = 3'd0;
    localparam ST_WAIT1    = 3'd1;
    localparam ST_RAMP1    = 3'd2;
    localparam ST_HOLD     = 3'd3;
    localparam ST_RAMP2    = 3'd4;
    localparam ST_PGDLY    = 3'd5;
    localparam ST_RUN      = 3'd6;
    localparam ST_STALL    = 3'd7;

    reg  [2:0]        state_reg;
    reg  [2:0]        state_next;
    reg  [REF_W-1:0]  target_reg;
    reg               drive_en_reg;
    reg               tmr_load;
    reg  [WAIT_W-1:0] tmr_count;
    wire              tmr_done;
    wire              start_ok;
    wire              mode8;
    wire              no_load;
    wire              at_target;

    // Decode of the 8-bit code mode, used more than once
    function is_mode8;
        input [1:0] m;
        begin
            is_mode8 = (m == `BSS_MODE_8BIT);
        end
    endfunction

    assign mode8     = is_mode8(code_mode_i);
    assign no_load   = (code_mode_i == `BSS_MODE_5BIT)
                       && (voltage_code_i[4:0] == `BSS_NO_LOAD_CODE);
    assign start_ok  = logic_supply_ok_i && enable_above_i
                       && driver_bias_supply_ok_i;
    // Exact match, so a code below the boot level still ramps down
    assign at_target = (ref_steps_o == target_reg);

    // ------------------------------------------------------------------
    // Wait timer
    // ------------------------------------------------------------------
    bss_delay_timer #(
        .WIDTH   (WAIT_W)
    ) u_timer (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .load_i  (tmr_load),
        .count_i (tmr_count),
        .done_o  (tmr_done)
    );

    // ------------------------------------------------------------------
    // Next state and timer loads
    // ------------------------------------------------------------------
    always @*
    begin
        state_next = state_reg;
        tmr_load   = 1'b0;
        tmr_count  = {WAIT_W{1'b0}};
        case (state_reg)
            ST_SHUTDOWN:
            begin
                if (start_ok && !no_load)
                begin
                    state_next = ST_WAIT1;
                    tmr_load   = 1'b1;
                    tmr_count  = INIT_WAIT[WAIT_W-1:0];
                end
            end
            ST_WAIT1:
                if (tmr_done)
                    state_next = ST_RAMP1;
            ST_RAMP1:
            begin
                if (at_target && mode8)
                begin
                    state_next = ST_HOLD;
                    tmr_load   = 1'b1;
                    tmr_count  = BOOT_HOLD[WAIT_W-1:0];
                end
                else if (at_target)
                    state_next = ST_RUN;
            end
            ST_HOLD:
            begin
                if (tmr_done && code_valid_i)
                    state_next = ST_RAMP2;
                else if (tmr_done)
                    state_next = ST_STALL;
            end
            ST_RAMP2:
            begin
                if (at_target)
                begin
                    state_next = ST_PGDLY;
                    tmr_load   = 1'b1;
                    tmr_count  = PG_DELAY[WAIT_W-1:0];
                end
            end
            ST_PGDLY:
                if (tmr_done)
                    state_next = ST_RUN;
            ST_RUN:
                state_next = ST_RUN;
            ST_STALL:
                state_next = ST_STALL;
            default:
                state_next = ST_SHUTDOWN;
        endcase
        if (!start_ok)
            state_next = ST_SHUTDOWN;
    end

    // ------------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------------
    // State, reference ramp and captured code
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg      <= ST_SHUTDOWN;
            ref_steps_o    <= {REF_W{1'b0}};
            target_reg     <= {REF_W{1'b0}};
            latched_code_o <= {CODE_W{1'b0}};
        end
        else
        begin
            state_reg <= state_next;
            if (state_next == ST_SHUTDOWN)
            begin
                ref_steps_o <= {REF_W{1'b0}};
                target_reg  <= {REF_W{1'b0}};
            end
            else if (state_reg == ST_SHUTDOWN)
            begin
                // 8-bit mode targets boot first, others target the code; every mode latches the code now
                latched_code_o <= voltage_code_i;
                target_reg     <= mode8 ? `BSS_BOOT_STEPS : code_steps_i;
            end
            else if (state_reg == ST_HOLD && state_next == ST_RAMP2)
            begin
                latched_code_o <= voltage_code_i;
                target_reg     <= code_steps_i;
            end
            // One 6.25 mV step per oscillator tick, up in either ramp, down only in the second ramp
            if ((state_reg == ST_RAMP1 || state_reg == ST_RAMP2)
                && ss_tick_i && ref_steps_o < target_reg)
                ref_steps_o <= ref_steps_o + {{(REF_W-1){1'b0}}, 1'b1};
            else if (state_reg == ST_RAMP2 && ss_tick_i
                     && ref_steps_o > target_reg)
                ref_steps_o <= ref_steps_o - {{(REF_W-1){1'b0}}, 1'b1};
        end
    end

    // Gate enable with pre-bias handling
    always @(posedge clk_i)
    begin
        if (rst_i || state_next == ST_SHUTDOWN || state_next == ST_STALL)
            drive_en_reg <= 1'b0;
        else if (state_next == ST_RUN)
            drive_en_reg <= 1'b1;
        else if (state_reg == ST_RAMP1 || state_reg == ST_RAMP2
                 || state_reg == ST_HOLD || state_reg == ST_PGDLY)
        begin
            if (!feedback_sense_above_i)
                drive_en_reg <= 1'b1;
        end
        else
            drive_en_reg <= 1'b0;
    end

    // Power good: in run state and in window in every mode; 8-bit mode reaches run after the delay
    always @(posedge clk_i)
    begin
        if (rst_i)
            power_good_out_o <= 1'b0;
        else if (state_reg == ST_RUN && output_sense_in_window_i)
            power_good_out_o <= 1'b1;
        else
            power_good_out_o <= 1'b0;
    end

    // Visible sequencer state
    always @(posedge clk_i)
    begin
        if (rst_i)
            seq_state_o <= ST_SHUTDOWN;
        else
            seq_state_o <= state_next;
    end

    // ------------------------------------------------------------------
    // Deadtime and gate drive
    // ------------------------------------------------------------------
    bss_deadtime u_deadtime (
        .clk_i            (clk_i),
        .rst_i            (rst_i),
        .drive_en_i       (drive_en_reg),
        .pwm_i            (pwm_i),
        .sw_node_low_i    (sw_node_low_i),
        .sw_node_rev_i    (sw_node_rev_i),
        .low_gate_below_i (low_gate_below_i),
        .high_gate_off_i  (high_gate_off_i),
        .sw_node_below_i  (sw_node_below_i),
        .high_side_gate_o (high_side_gate_o),
        .low_side_gate_o  (low_side_gate_o)
    );

endmodule // bss_softstart_seq

// *** verif/bss_seq_sva.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Start-up and gate timing checks
// ----------------------------------------------------------------
module bss_seq_sva #(
    parameter CODE_W    = 8,
    parameter REF_W     = 12,
    parameter INIT_WAIT = 20
) (
    // Clock, reset and supplies
    input wire              clk_i,
    input wire              rst_i,
    input wire              logic_supply_ok_i,
    input wire              enable_above_i,
    input wire              driver_bias_supply_ok_i,
    // Mode, code and comparators
    input wire [1:0]        code_mode_i,
    input wire [CODE_W-1:0] voltage_code_i,
    input wire              ss_tick_i,
    input wire              feedback_sense_above_i,
    input wire              output_sense_in_window_i,
    // Outputs watched
    input wire              high_side_gate_o,
    input wire              low_side_gate_o,
    input wire              power_good_out_o,
    input wire [REF_W-1:0]  ref_steps_o,
    input wire [2:0]        seq_state_o
);
    wire       sup_ok = logic_supply_ok_i && enable_above_i && driver_bias_supply_ok_i;
    reg [19:0] wait_cnt;

    // Cycles spent in the initial wait
    always @(posedge clk_i)
        wait_cnt <= (rst_i || seq_state_o != 3'd1) ? 20'd0 : wait_cnt + 20'd1;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_SHUT_GATES: assert property ((seq_state_o == 3'd0) [*3] |->
        !high_side_gate_o && !low_side_gate_o) else $error("gates on in shutdown");
    AST_START_SUPPLY: assert property ($past(seq_state_o) == 3'd0 && seq_state_o == 3'd1
        |-> $past(sup_ok)) else $error("start without supplies");
    AST_DROP_SHUT: assert property (seq_state_o != 3'd0 && !sup_ok |=>
        seq_state_o == 3'd0) else $error("no shutdown on supply drop");
    AST_NO_LOAD: assert property (seq_state_o == 3'd0 && code_mode_i == 2'd1 &&
        voltage_code_i[4:0] == 5'h1f |=> seq_state_o == 3'd0) else $error("no-load start");
    AST_IMMEDIATE: assert property (seq_state_o == 3'd0 && sup_ok && code_mode_i != 2'd1
        |=> seq_state_o == 3'd1) else $error("start delayed");
    AST_INIT_WAIT: assert property ($past(seq_state_o) == 3'd1 && seq_state_o == 3'd2
        |-> wait_cnt >= INIT_WAIT - 1 && wait_cnt <= INIT_WAIT + 1) else $error("wait length");
    AST_REF_STEP: assert property ($past(seq_state_o) == 3'd2 && seq_state_o == 3'd2 &&
        ref_steps_o != $past(ref_steps_o) |-> ref_steps_o == $past(ref_steps_o) + 1'b1 &&
        $past(ss_tick_i)) else $error("reference step");
    AST_BOOT_LEVEL: assert property ($past(seq_state_o) == 3'd2 && seq_state_o == 3'd3
        |-> ref_steps_o == 12'd176) else $error("boot level");
    AST_PG_RUN: assert property ($rose(power_good_out_o) |-> seq_state_o == 3'd6 &&
        $past(output_sense_in_window_i)) else $error("power good early");
    AST_PREBIAS: assert property ((seq_state_o == 3'd2 && feedback_sense_above_i) [*3]
        |-> !high_side_gate_o && !low_side_gate_o) else $error("gates on over precharge");
    AST_NO_OVERLAP: assert property (!(high_side_gate_o && low_side_gate_o))
        else $error("both gates on");
endmodule // bss_seq_sva

bind bss_softstart_seq bss_seq_sva #(.CODE_W(CODE_W), .REF_W(REF_W), .INIT_WAIT(INIT_WAIT))
    i_sva (.clk_i(clk_i), .rst_i(rst_i), .logic_supply_ok_i(logic_supply_ok_i),
    .enable_above_i(enable_above_i), .driver_bias_supply_ok_i(driver_bias_supply_ok_i),
    .code_mode_i(code_mode_i), .voltage_code_i(voltage_code_i), .ss_tick_i(ss_tick_i),
    .feedback_sense_above_i(feedback_sense_above_i),
    .output_sense_in_window_i(output_sense_in_window_i),
    .high_side_gate_o(high_side_gate_o), .low_side_gate_o(low_side_gate_o),
    .power_good_out_o(power_good_out_o), .ref_steps_o(ref_steps_o), .seq_state_o(seq_state_o));

// *** verif/bss_stage_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Power stage and sense comparator model
// ----------------------------------------------------------------
module bss_stage_model (
    // Clock
    input  wire        clk_i,
    // Gate commands and reference
    input  wire        high_side_gate_i,
    input  wire        low_side_gate_i,
    input  wire [11:0] ref_steps_i,
    // Scenario controls
    input  wire [11:0] precharge_i,
    input  wire        zero_current_i,
    // Comparator results
    output reg         sw_node_low_o,
    output reg         sw_node_rev_o,
    output reg         low_gate_below_o,
    output reg         high_gate_off_o,
    output reg         sw_node_below_o,
    output wire        feedback_sense_above_o
);
    // Output sits at its precharge until the reference passes it
    assign feedback_sense_above_o = precharge_i > ref_steps_i;

    // Gate and switch node levels follow the commands one cycle late
    always @(posedge clk_i)
    begin
        low_gate_below_o <= !low_side_gate_i;
        sw_node_low_o    <= !low_side_gate_i && !zero_current_i;
        sw_node_rev_o    <= 1'b0;
        high_gate_off_o  <= !high_side_gate_i;
        sw_node_below_o  <= !high_side_gate_i;
    end
endmodule // bss_stage_model

// *** verif/tb_buck_softstart_deadtime_seq.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Start-up sequencer testbench
// ----------------------------------------------------------------
module tb_buck_softstart_deadtime_seq;
    localparam HOLD = 10;
    reg         clk_i  = 1'b0;
    reg         rst_i  = 1'b1;
    reg  [2:0]  sup    = 3'd0;
    reg  [1:0]  mode   = 2'd0;
    reg  [7:0]  vcode  = 8'h00;
    reg         cvalid = 1'b0;
    reg  [11:0] csteps = 12'h0000;
    reg         tick   = 1'b0;
    reg         win    = 1'b1;
    reg         pwm    = 1'b1;
    reg  [11:0] pre    = 12'h0000;
    reg         zc     = 1'b0;
    wire        hg, lg, pg, sw_low, sw_rev, lg_below, hg_off, sw_below, fb_above;
    wire [11:0] refs;
    wire [2:0]  st;
    wire [7:0]  lcode;
    integer     fail_count = 0;
    integer     checked    = 0;
    integer     n, nf, i;

    bss_softstart_seq #(.INIT_WAIT(20), .BOOT_HOLD(HOLD), .PG_DELAY(HOLD)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .logic_supply_ok_i(sup[0]), .enable_above_i(sup[1]),
        .driver_bias_supply_ok_i(sup[2]), .code_mode_i(mode), .voltage_code_i(vcode),
        .code_valid_i(cvalid), .code_steps_i(csteps), .ss_tick_i(tick),
        .feedback_sense_above_i(fb_above), .output_sense_in_window_i(win), .pwm_i(pwm),
        .sw_node_low_i(sw_low), .sw_node_rev_i(sw_rev), .low_gate_below_i(lg_below),
        .high_gate_off_i(hg_off), .sw_node_below_i(sw_below), .high_side_gate_o(hg),
        .low_side_gate_o(lg), .power_good_out_o(pg), .ref_steps_o(refs),
        .seq_state_o(st), .latched_code_o(lcode));

    bss_stage_model i_stage (.clk_i(clk_i), .high_side_gate_i(hg), .low_side_gate_i(lg),
        .ref_steps_i(refs), .precharge_i(pre), .zero_current_i(zc), .sw_node_low_o(sw_low),
        .sw_node_rev_o(sw_rev), .low_gate_below_o(lg_below), .high_gate_off_o(hg_off),
        .sw_node_below_o(sw_below), .feedback_sense_above_o(fb_above));

    // 100 MHz clock
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    // Oscillator tick, high every other cycle
    always @(negedge clk_i)
        tick <= ~tick;

    task check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    begin
        checked = checked + 1;
        if (seen !== exp)
        begin
            fail_count = fail_count + 1;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    end
    endtask

    task cyc(input integer k);
    begin
        repeat (k) @(negedge clk_i);
    end
    endtask

    // Waits for a state under a bound; n holds the cycles taken
    task wait_st(input [2:0] s);
    begin
        n = 0;
        while (st !== s && n < 5000)
        begin
            cyc(1);
            n = n + 1;
        end
        check("state", st, s);
    end
    endtask

    task power_up(input [1:0] m, input [7:0] c, input [11:0] s, input v);
    begin
        sup = 3'd0;
        cyc(3);
        mode = m;
        vcode = c;
        csteps = s;
        cvalid = v;
        sup = 3'b111;
        cyc(1);
    end
    endtask

    task t_supply;
    begin
        check("reset gates", {hg, lg, pg, st}, 12'h0000);
        for (i = 0; i < 7; i = i + 1)
        begin
            sup = i;
            cyc(3);
            check("partial supply", st, 3'd0);
            check("partial gates", {hg, lg}, 2'b00);
        end
    end
    endtask

    task t_no_load;
    begin
        power_up(2'd1, 8'h1f, 12'h0028, 1'b1);
        cyc(4);
        check("no-load refused", st, 3'd0);
        vcode = 8'h0e;
        cyc(1);
        check("5-bit start", st, 3'd1);
        vcode = 8'h03;
        wait_st(3'd2);
        check("5-bit wait", n >= 18 && n <= 22, 1);
        check("captured code", lcode, 8'h0e);
        wait_st(3'd6);
        check("5-bit ramp end", refs, 12'h0028);
        cyc(2);
        check("5-bit power good", pg, 1);
    end
    endtask

    task t_boot_ramp;
    begin
        power_up(2'd0, 8'h00, 12'h00c8, 1'b0);
        check("8-bit start", st, 3'd1);
        wait_st(3'd2);
        check("8-bit wait", n >= 18 && n <= 22, 1);
        wait_st(3'd3);
        check("first ramp time", n >= 348 && n <= 356, 1);
        check("boot level", refs, 12'h00b0);
        cyc(3);
        cvalid = 1'b1;
        wait_st(3'd4);
        check("boot hold", n >= HOLD - 5 && n <= HOLD - 1, 1);
        wait_st(3'd5);
        check("second ramp time", n >= 44 && n <= 52, 1);
        check("code level", refs, 12'h00c8);
        check("no early power good", pg, 0);
        wait_st(3'd6);
        check("power good delay", n >= HOLD - 1 && n <= HOLD + 1, 1);
        cyc(2);
        check("8-bit power good", pg, 1);
    end
    endtask

    // Code below the boot level: second ramp steps downward
    task t_ramp_down;
    begin
        power_up(2'd0, 8'h00, 12'h0050, 1'b1);
        wait_st(3'd4);
        wait_st(3'd5);
        check("ramp down time", n >= 188 && n <= 196, 1);
        check("ramp down level", refs, 12'h0050);
    end
    endtask

    task t_invalid;
    begin
        power_up(2'd0, 8'h00, 12'h00c8, 1'b0);
        wait_st(3'd7);
        cyc(2);
        check("invalid code gates", {hg, lg, pg}, 3'b000);
        rst_i = 1'b1;
        cyc(1);
        check("mid-run reset", {hg, lg, st}, 5'h00);
        rst_i = 1'b0;
    end
    endtask

    task t_prebias;
    begin
        pre = 12'h003c;
        win = 1'b0;
        power_up(2'd2, 8'h10, 12'h0064, 1'b1);
        check("6-bit start", st, 3'd1);
        wait_st(3'd2);
        cyc(100);
        check("gates held over precharge", {hg, lg}, 2'b00);
        cyc(40);
        check("gates released", {hg, lg}, 2'b10);
        wait_st(3'd6);
        cyc(3);
        check("power good outside window", pg, 0);
        pwm = 1'b0;
        cyc(1);
        check("high gate off", hg, 0);
        cyc(4);
        check("low gate on", lg, 1);
        for (i = 0; i < 2; i = i + 1)
        begin
            zc = i;
            pwm = 1'b0;
            cyc(6);
            pwm = 1'b1;
            n = 0;
            while (hg !== 1'b1 && n < 50)
            begin
                cyc(1);
                n = n + 1;
            end
            if (i == 0)
                nf = n;
        end
        check("node blanking", nf >= 4 && nf < 50, 1);
        check("zero current delay", n >= 6 && n > nf && n < 50, 1);
        zc = 1'b0;
    end
    endtask

    task t_precharged;
    begin
        pre = 12'h0096;
        power_up(2'd2, 8'h10, 12'h0064, 1'b1);
        win = 1'b1;
        wait_st(3'd2);
        cyc(150);
        check("gates off whole ramp", {hg, lg}, 2'b00);
        wait_st(3'd6);
        cyc(6);
        check("gates on at end", {hg, lg}, 2'b10);
    end
    endtask

    task close_out;
    begin
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask

    // Cuts a hung run short
    initial
    begin
        #400000;
        fail_count = fail_count + 1;
        close_out;
    end

    // Main sequence
    initial
    begin
        cyc(3);
        rst_i = 1'b0;
        t_supply;
        t_no_load;
        t_boot_ramp;
        t_ramp_down;
        t_invalid;
        t_prebias;
        t_precharged;
        close_out;
    end
endmodule // tb_buck_softstart_deadtime_seq
